// ### src/rre_exec_unit.sv
// Return, rotate and mode-clear execution unit of the core
//
// Contract
// - A met conditional return pops the stack into the PC, else nothing.
// - A delayed conditional return lands after two more words execute.
// - The enabling irq return pops into the PC and clears the irq mask.
// - The enabling irq return copies every shadow into its working reg.
// - Shadows cover both accs, product, status, mode, compare, index, temps.
// - The plain irq return pops to the PC, restores shadows, forces no mask.
// - The frame sync clear sets the frame sync mode bit to zero.
// - The hold mode clear instruction sets the hold mode bit to zero.
// - The accumulator rotate left moves the accumulator left by one bit.
// - The accumulator rotate right moves the accumulator right by one bit.
// - The pair rotate left turns buffer and acc left as one 65-bit ring.
// - The pair rotate right turns buffer and acc right as one 65-bit ring.
`timescale 1ns/1ps

module rre_exec_unit
  import rre_pkg::*;
(
  input  wire logic                SYS_CLK,
  input  wire logic                RESET,
  input  wire rre_pkg::rre_req_s   REQ,
  input  wire logic                LOAD_CTX,
  input  wire rre_pkg::rre_ctx_s   LOAD_VALUE,
  output rre_pkg::rre_ctx_s        CTX,
  output rre_pkg::rre_ctx_s        SHADOW,
  output rre_pkg::rre_flow_s       FLOW,
  output logic [rre_pkg::SP_W-1:0] STACK_LEVEL
);

  import rre_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    rre_ctx_s          ctx;
    rre_ctx_s          shadow;
    rre_state_e        state;
    logic [DCNT_W-1:0] dcnt;
    logic [PC_W-1:0]   ret_pc;
    rre_flow_s         flow;
  } rre_unit_s;

  rre_unit_s       r;
  rre_unit_s       next_r;
  logic            stk_push;
  logic            stk_pop;
  logic [PC_W-1:0] stk_top;

  // True when all selected conditions hold; empty mask means always
  function automatic logic conds_met(input logic [COND_W-1:0] mask,
                                     input logic [COND_W-1:0] truth);
    conds_met = ((mask & truth) == mask);
  endfunction

  // Rotate a vector one place through carry, returning {carry, value}
  function automatic logic [2*DATA_W:0] rot_thru_carry(
    input logic [2*DATA_W-1:0] v,
    input logic                cin,
    input logic                left,
    input logic                pair);
    logic [2*DATA_W:0] res;
    res = '0;
    if (pair)
    begin
      if (left)
        res = {v[2*DATA_W-1], v[2*DATA_W-2:0], cin};
      else
        res = {v[0], cin, v[2*DATA_W-1:1]};
    end
    else
    begin
      if (left)
        res = {v[DATA_W-1], DATA_W'(0), v[DATA_W-2:0], cin};
      else
        res = {v[0], DATA_W'(0), cin, v[DATA_W-1:1]};
    end
    rot_thru_carry = res;
  endfunction

  // Pair rotates also move the buffer half; acc-only ones leave it alone
  function automatic logic is_pair_rot(input rre_op_e op);
    is_pair_rot = (op == RRE_OP_PAIR_ROTATE_LEFT ||
                   op == RRE_OP_PAIR_ROTATE_RIGHT);
  endfunction

  // Left rotates of either width
  function automatic logic is_left_rot(input rre_op_e op);
    is_left_rot = (op == RRE_OP_ACC_ROTATE_LEFT ||
                   op == RRE_OP_PAIR_ROTATE_LEFT);
  endfunction

  // ------------------------------------------------------------------
  // Return-address stack
  // ------------------------------------------------------------------
  rre_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk        (SYS_CLK),
    .reset      (RESET),
    .push       (stk_push),
    .push_value (REQ.push_pc),
    .pop        (stk_pop),
    .top        (stk_top),
    .level      (STACK_LEVEL)
  );

  // Stack push for calls and interrupt entry, pop on taken returns
  always_comb
  begin
    stk_push = REQ.valid && (REQ.op == RRE_OP_PUSH_CALL ||
                             REQ.op == RRE_OP_IRQ_TAKE);
    stk_pop  = 1'b0;
    if (REQ.valid && r.state == RRE_ST_RUN)
    begin
      case (REQ.op)
        RRE_OP_COND_RETURN, RRE_OP_COND_RETURN_DELAYED:
          stk_pop = conds_met(REQ.cond_mask, REQ.cond_true);
        RRE_OP_IRQ_RETURN_ENABLE, RRE_OP_IRQ_RETURN:
          stk_pop = 1'b1;
        default:
          stk_pop = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [2*DATA_W:0] rot;
    logic              cin;
    rot    = '0;
    cin    = r.ctx.status_reg_b[ST_B_CARRY_POS];
    next_r = r;
    next_r.flow.pc_load = 1'b0;

    // Software load of working context (e.g. by other instructions)
    if (LOAD_CTX)
      next_r.ctx = LOAD_VALUE;

    // Delay slot counting; non-return ops in the slots still execute
    if (r.state == RRE_ST_DELAY && REQ.valid && REQ.word_done)
    begin
      if (r.dcnt == DCNT_ONE)
      begin
        next_r.state         = RRE_ST_RUN;
        next_r.dcnt          = '0;
        next_r.flow.pc_load  = 1'b1;
        next_r.flow.pc_value = r.ret_pc;
      end
      else
        next_r.dcnt = r.dcnt - DCNT_ONE;
    end

    if (REQ.valid)
    begin
      case (REQ.op)
        RRE_OP_COND_RETURN:
          if (r.state == RRE_ST_RUN && stk_pop)
          begin
            next_r.flow.pc_load  = 1'b1;
            next_r.flow.pc_value = stk_top;
          end
        RRE_OP_COND_RETURN_DELAYED:
          if (r.state == RRE_ST_RUN && stk_pop)
          begin
            next_r.state  = RRE_ST_DELAY;
            next_r.dcnt   = DCNT_W'(DELAY_WORDS);
            next_r.ret_pc = stk_top;
          end
        RRE_OP_IRQ_RETURN_ENABLE, RRE_OP_IRQ_RETURN:
          if (r.state == RRE_ST_RUN)
          begin
            next_r.flow.pc_load  = 1'b1;
            next_r.flow.pc_value = stk_top;
            next_r.ctx           = r.shadow;
            if (REQ.op == RRE_OP_IRQ_RETURN_ENABLE)
              next_r.ctx.status_reg_a[ST_A_INTM_POS] = 1'b0;
          end
        RRE_OP_IRQ_TAKE:
          // Capture all shadowed registers at interrupt entry
          next_r.shadow = r.ctx;
        RRE_OP_CLEAR_FRAME_SYNC:
          next_r.ctx.status_reg_b[ST_B_FSM_POS] = 1'b0;
        RRE_OP_CLEAR_HOLD_MODE:
          next_r.ctx.status_reg_b[ST_B_HM_POS] = 1'b0;
        RRE_OP_ACC_ROTATE_LEFT, RRE_OP_ACC_ROTATE_RIGHT,
        RRE_OP_PAIR_ROTATE_LEFT, RRE_OP_PAIR_ROTATE_RIGHT:
        begin
          // Rotates read the old context, so a same-cycle load of the rotated bits and carry is overruled
          rot = rot_thru_carry({r.ctx.acc_buffer, r.ctx.acc}, cin,
                               is_left_rot(REQ.op),
                               is_pair_rot(REQ.op));
          next_r.ctx.acc = rot[DATA_W-1:0];
          if (is_pair_rot(REQ.op))
            next_r.ctx.acc_buffer = rot[2*DATA_W-1:DATA_W];
          next_r.ctx.status_reg_b[ST_B_CARRY_POS] = rot[2*DATA_W];
        end
        default:
          next_r.ctx = next_r.ctx;
      endcase
    end
    next_r.flow.busy_delay = (next_r.state == RRE_ST_DELAY);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      r.ctx    <= CTX_RST;
      r.shadow <= CTX_RST;
      r.state  <= RRE_ST_RUN;
      r.dcnt   <= '0;
      r.ret_pc <= PC_RST;
      r.flow   <= '{pc_load: 1'b0, pc_value: PC_RST, busy_delay: 1'b0};
    end
    else
      r <= next_r;
  end

  assign CTX    = r.ctx;
  assign SHADOW = r.shadow;
  assign FLOW   = r.flow;

endmodule

// ### src/rre_pkg.sv
// Package: shared widths, reset values, opcodes and carrier structs
package rre_pkg;

  // ------------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------------
  localparam int DATA_W      = 32;
  localparam int WORD_W      = 16;
  localparam int PC_W        = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 4;
  localparam int COND_W      = 8;
  localparam int DELAY_WORDS = 2;
  localparam int DCNT_W      = 2;

  // ------------------------------------------------------------------
  // Reset values and status bit positions
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST    = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST   = 16'h0000;
  localparam logic [PC_W-1:0]   PC_RST     = 16'h0000;
  localparam logic [SP_W-1:0]   SP_RST     = 4'h0;
  localparam logic [DCNT_W-1:0] DCNT_ONE   = 2'h1;
  localparam int  ST_A_INTM_POS  = 9;   // Global irq mask in status_reg_a
  localparam int  ST_B_CARRY_POS = 9;   // Carry in status_reg_b
  localparam int  ST_B_HM_POS    = 6;   // hold_mode_bit in status_reg_b
  localparam int  ST_B_FSM_POS   = 5;   // frame_sync_mode_bit in status_reg_b

  // ------------------------------------------------------------------
  // Operations
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    RRE_OP_NOP                 = 4'h0,
    RRE_OP_COND_RETURN         = 4'h1,
    RRE_OP_COND_RETURN_DELAYED = 4'h2,
    RRE_OP_IRQ_RETURN_ENABLE   = 4'h3,
    RRE_OP_IRQ_RETURN          = 4'h4,
    RRE_OP_CLEAR_FRAME_SYNC    = 4'h5,
    RRE_OP_CLEAR_HOLD_MODE     = 4'h6,
    RRE_OP_ACC_ROTATE_LEFT     = 4'h7,
    RRE_OP_ACC_ROTATE_RIGHT    = 4'h8,
    RRE_OP_PAIR_ROTATE_LEFT    = 4'h9,
    RRE_OP_PAIR_ROTATE_RIGHT   = 4'ha,
    RRE_OP_PUSH_CALL           = 4'hb,
    RRE_OP_IRQ_TAKE            = 4'hc
  } rre_op_e;

  typedef enum logic [1:0] {
    RRE_ST_RUN   = 2'b00,
    RRE_ST_DELAY = 2'b01
  } rre_state_e;

  // ------------------------------------------------------------------
  // Carrier structs
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] acc_buffer;
    logic [DATA_W-1:0] product_reg;
    logic [WORD_W-1:0] status_reg_a;
    logic [WORD_W-1:0] status_reg_b;
    logic [WORD_W-1:0] proc_mode_status;
    logic [WORD_W-1:0] aux_compare_reg;
    logic [WORD_W-1:0] index_reg;
    logic [WORD_W-1:0] temp_reg_a;
    logic [WORD_W-1:0] temp_reg_b;
    logic [WORD_W-1:0] temp_reg_c;
  } rre_ctx_s;

  localparam rre_ctx_s CTX_RST = '{ACC_RST, ACC_RST, ACC_RST, WORD_RST,
    WORD_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST};

  typedef struct packed {
    logic              valid;
    rre_op_e           op;
    logic [COND_W-1:0] cond_mask;
    logic [COND_W-1:0] cond_true;
    logic              word_done;
    logic [PC_W-1:0]   push_pc;
  } rre_req_s;

  typedef struct packed {
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            busy_delay;
  } rre_flow_s;

endpackage

// ### src/rre_stack.sv
// Hardware return-address stack with push and pop
`timescale 1ns/1ps

module rre_stack
  import rre_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       push,
  input  wire logic [rre_pkg::PC_W-1:0]   push_value,
  input  wire logic                       pop,
  output logic      [rre_pkg::PC_W-1:0]   top,
  output logic      [rre_pkg::SP_W-1:0]   level
);

  import rre_pkg::*;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [SP_W-1:0] sp;
  } rre_stk_s;

  logic [PC_W-1:0] mem [DEPTH];
  rre_stk_s        r;
  rre_stk_s        next_r;

  // Top entry; an empty stack returns zero instead of stale data
  assign top   = (r.sp == SP_RST) ? PC_RST : mem[(SP_W-1)'(r.sp - 4'h1)];
  assign level = r.sp;

  // Pointer update; overflow saturates, underflow holds at empty
  always_comb
  begin
    next_r = r;
    if (push && !pop && r.sp != SP_W'(DEPTH))
      next_r.sp = r.sp + 4'h1;
    else if (pop && !push && r.sp != SP_RST)
      next_r.sp = r.sp - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      r <= '{sp: SP_RST};
    else
      r <= next_r;
  end

  // Entries hold no reset; they are only read below the pointer
  always_ff @(posedge clk)
  begin
    if (push && !pop && r.sp != SP_W'(DEPTH))
      mem[r.sp[SP_W-2:0]] <= push_value;
  end

endmodule

// ### tb/rre_exec_unit_properties.sv
// Port checker for the return, rotate and mode-clear unit
`timescale 1ns/1ps
module rre_exec_unit_checker
  import rre_pkg::*;
(
  input wire logic                     SYS_CLK,
  input wire logic                     RESET,
  input wire rre_pkg::rre_req_s        REQ,
  input wire logic                     LOAD_CTX,
  input wire rre_pkg::rre_ctx_s        LOAD_VALUE,
  input wire rre_pkg::rre_ctx_s        CTX,
  input wire rre_pkg::rre_ctx_s        SHADOW,
  input wire rre_pkg::rre_flow_s       FLOW,
  input wire logic [rre_pkg::SP_W-1:0] STACK_LEVEL
);
  import rre_pkg::*;
  // ----------
  // Decoded view
  // ----------
  // Same-cycle context loads blur ownership, so they are left out
  logic [3:0] opv;
  logic       met;
  logic       pop_ok;
  logic       c;
  assign opv = (REQ.valid && !LOAD_CTX) ? REQ.op : 4'h0;
  assign met = (REQ.cond_mask & ~REQ.cond_true) == 8'h00;
  assign pop_ok = !FLOW.busy_delay && STACK_LEVEL != 4'h0;
  assign c = CTX.status_reg_b[ST_B_CARRY_POS];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Delayed return: start, then two completed words
  sequence s_dly_go;
    opv == RRE_OP_COND_RETURN_DELAYED && met && pop_ok;
  endsequence
  sequence s_slots;
    REQ.word_done [*2];
  endsequence
  a_delay_wait: assert property (
    s_dly_go |=> (FLOW.busy_delay && !FLOW.pc_load) [*2])
    else $error("delayed return landed early");
  a_delay_land: assert property (
    s_dly_go ##1 s_slots |=> FLOW.pc_load && !FLOW.busy_delay)
    else $error("delayed return missed its slot");
  a_cond_skip: assert property (
    opv == RRE_OP_COND_RETURN && !met && !FLOW.busy_delay
      |=> !FLOW.pc_load && $stable(STACK_LEVEL))
    else $error("unmet return changed flow");
  a_cond_pop: assert property (
    opv == RRE_OP_COND_RETURN && met && pop_ok
      |=> FLOW.pc_load && STACK_LEVEL == $past(STACK_LEVEL) - 4'h1)
    else $error("met return did not pop");
  a_irq_enable: assert property (
    opv == RRE_OP_IRQ_RETURN_ENABLE && pop_ok |=> FLOW.pc_load
      && !CTX.status_reg_a[ST_A_INTM_POS] && CTX.acc == $past(SHADOW.acc)
      && CTX.temp_reg_c == $past(SHADOW.temp_reg_c))
    else $error("enabling return restore wrong");
  a_irq_plain: assert property (
    opv == RRE_OP_IRQ_RETURN && pop_ok
      |=> FLOW.pc_load && CTX == $past(SHADOW))
    else $error("plain return restore wrong");
  a_fsm_clear: assert property (
    opv == RRE_OP_CLEAR_FRAME_SYNC |=> !CTX.status_reg_b[ST_B_FSM_POS])
    else $error("frame sync bit not cleared");
  a_hm_clear: assert property (
    opv == RRE_OP_CLEAR_HOLD_MODE |=> !CTX.status_reg_b[ST_B_HM_POS])
    else $error("hold bit not cleared");
  a_acc_rol: assert property (
    opv == RRE_OP_ACC_ROTATE_LEFT
      |=> {c, CTX.acc} == {$past(CTX.acc), $past(c)})
    else $error("acc rotate left wrong");
  a_acc_ror: assert property (
    opv == RRE_OP_ACC_ROTATE_RIGHT
      |=> {CTX.acc, c} == {$past(c), $past(CTX.acc)})
    else $error("acc rotate right wrong");
  a_pair_rol: assert property (
    opv == RRE_OP_PAIR_ROTATE_LEFT |=> {c, CTX.acc_buffer, CTX.acc}
      == {$past(CTX.acc_buffer), $past(CTX.acc), $past(c)})
    else $error("pair rotate left wrong");
  a_pair_ror: assert property (
    opv == RRE_OP_PAIR_ROTATE_RIGHT |=> {CTX.acc_buffer, CTX.acc, c}
      == {$past(c), $past(CTX.acc_buffer), $past(CTX.acc)})
    else $error("pair rotate right wrong");
endmodule

bind rre_exec_unit rre_exec_unit_checker u_rre_exec_unit_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REQ(REQ), .LOAD_CTX(LOAD_CTX),
  .LOAD_VALUE(LOAD_VALUE), .CTX(CTX), .SHADOW(SHADOW), .FLOW(FLOW),
  .STACK_LEVEL(STACK_LEVEL));

// ### tb/rre_stream_model.sv
// Instruction stream model feeding the execution unit
`timescale 1ns/1ps
module rre_stream_model
  import rre_pkg::*;
(
  input  wire logic                       issue,
  input  wire rre_pkg::rre_op_e           op,
  input  wire logic [rre_pkg::COND_W-1:0] mask,
  input  wire logic [rre_pkg::COND_W-1:0] truth,
  input  wire logic [rre_pkg::PC_W-1:0]   pc,
  output rre_pkg::rre_req_s               req
);
  import rre_pkg::*;
  // One-word fetches, so each also closes a word; idle fields carry
  // inverted junk so the unit cannot lean on stale values
  assign req = issue ? {1'b1, op, mask, truth, 1'b1, pc}
                     : {1'b0, ~op, ~mask, ~truth, 1'b0, ~pc};
endmodule

// ### tb/test_rre_exec_unit.sv
// Self-checking bench for the return, rotate and mode-clear unit
`timescale 1ns/1ps
module test_rre_exec_unit;
  import rre_pkg::*;
  // ----------
  // Signals and reference state
  // ----------
  typedef struct packed {
    logic            ld;
    logic            bsy;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] lvl;
    rre_ctx_s        ctx;
    rre_ctx_s        sh;
  } rre_note_s;
  logic              SYS_CLK = 1'b0;
  logic              RESET = 1'b1;
  logic              LOAD_CTX = 1'b0;
  logic              go = 1'b0;
  rre_op_e           op = RRE_OP_NOP;
  logic [COND_W-1:0] msk = 8'h00;
  logic [COND_W-1:0] tru = 8'h00;
  logic [PC_W-1:0]   ppc = 16'h0000;
  rre_ctx_s          LOAD_VALUE = CTX_RST;
  rre_req_s          REQ;
  rre_ctx_s          CTX;
  rre_ctx_s          SHADOW;
  rre_flow_s         FLOW;
  logic [SP_W-1:0]   STACK_LEVEL;
  rre_note_s         q[$];
  rre_ctx_s          m = CTX_RST;
  rre_ctx_s          sh = CTX_RST;
  logic [PC_W-1:0]   stk[$];
  logic [PC_W-1:0]   dret;
  int                dcnt = 0;
  int                err_total = 0;
  int                checks = 0;
  integer            seed = 6;
  // 10 MHz clock
  always #50 SYS_CLK = ~SYS_CLK;
  // Unit under test and its fetch side
  rre_stream_model u_rre_stream_model (.issue(go), .op(op), .mask(msk),
    .truth(tru), .pc(ppc), .req(REQ));
  rre_exec_unit u_rre_exec_unit (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .REQ(REQ), .LOAD_CTX(LOAD_CTX), .LOAD_VALUE(LOAD_VALUE), .CTX(CTX),
    .SHADOW(SHADOW), .FLOW(FLOW), .STACK_LEVEL(STACK_LEVEL));
  // Note what the unit must show after the coming edge
  task automatic note(logic ld, logic [PC_W-1:0] pc);
    q.push_back({ld, (dcnt != 0), pc, SP_W'(stk.size()), m, sh});
  endtask
  // Random context; mode and mask bits set so clears and restores show
  task automatic load();
    rre_ctx_s v;
    for (int i = 0; i < 7; i++)
      v = {v[191:0], 32'($random(seed))};
    v.status_reg_b[ST_B_HM_POS] = 1'b1;
    v.status_reg_b[ST_B_FSM_POS] = 1'b1;
    v.status_reg_a[ST_A_INTM_POS] = 1'b1;
    @(negedge SYS_CLK);
    go = 1'b0;
    LOAD_CTX = 1'b1;
    LOAD_VALUE = v;
    m = v;
    note(1'b0, 16'h0000);
  endtask
  // One instruction, with the reference state stepped alongside
  task automatic step(rre_op_e o, logic [7:0] mk = 8'h00,
                      logic [7:0] tr = 8'h00);
    logic            busy;
    logic            ld;
    logic            c;
    logic [PC_W-1:0] pc;
    busy = dcnt != 0;
    ld = 1'b0;
    pc = 16'h0000;
    c = m.status_reg_b[ST_B_CARRY_POS];
    @(negedge SYS_CLK);
    LOAD_CTX = 1'b0;
    go = 1'b1;
    op = o;
    msk = mk;
    tru = tr;
    ppc = 16'($random(seed));
    if (busy)
      dcnt--;
    if (busy && dcnt == 0)
      {ld, pc} = {1'b1, dret};
    case (o)
      RRE_OP_ACC_ROTATE_LEFT: {c, m.acc} = {m.acc, c};
      RRE_OP_ACC_ROTATE_RIGHT: {m.acc, c} = {c, m.acc};
      RRE_OP_PAIR_ROTATE_LEFT:
        {c, m.acc_buffer, m.acc} = {m.acc_buffer, m.acc, c};
      RRE_OP_PAIR_ROTATE_RIGHT:
        {m.acc_buffer, m.acc, c} = {c, m.acc_buffer, m.acc};
      RRE_OP_CLEAR_FRAME_SYNC: m.status_reg_b[ST_B_FSM_POS] = 1'b0;
      RRE_OP_CLEAR_HOLD_MODE: m.status_reg_b[ST_B_HM_POS] = 1'b0;
      RRE_OP_PUSH_CALL: stk.push_back(ppc);
      RRE_OP_IRQ_TAKE:
      begin
        sh = m;
        stk.push_back(ppc);
      end
      RRE_OP_NOP: ;
      default:
        if (!busy && (mk & ~tr) == 8'h00)
        begin
          // An empty stack still returns, to address zero
          if (stk.size() > 0)
            pc = stk.pop_back();
          if (o == RRE_OP_COND_RETURN_DELAYED)
          begin
            dret = pc;
            dcnt = DELAY_WORDS;
          end
          else
          begin
            ld = 1'b1;
            if (o != RRE_OP_COND_RETURN)
              m = sh;
            if (o == RRE_OP_IRQ_RETURN_ENABLE)
              m.status_reg_a[ST_A_INTM_POS] = 1'b0;
            c = m.status_reg_b[ST_B_CARRY_POS];
          end
        end
    endcase
    m.status_reg_b[ST_B_CARRY_POS] = c;
    note(ld, pc);
  endtask
  // Monitor: oldest note against the settled outputs
  always @(posedge SYS_CLK)
  begin
    rre_note_s n;
    #1;
    if (q.size() > 0)
    begin
      n = q.pop_front();
      checks++;
      if (FLOW.pc_load !== n.ld || (n.ld && FLOW.pc_value !== n.pc) ||
          FLOW.busy_delay !== n.bsy || STACK_LEVEL !== n.lvl ||
          CTX !== n.ctx || SHADOW !== n.sh)
      begin
        $display("CHECK FAILED %0t: outputs differ from model", $time);
        err_total++;
      end
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge SYS_CLK);
    RESET = 1'b0;
    note(1'b0, PC_RST); // Reset values hold on the first idle edge
    load();
    for (int k = 0; k < 8; k++)
      step(rre_op_e'(4'h7 + 4'(k % 4)));
    step(RRE_OP_CLEAR_FRAME_SYNC);
    step(RRE_OP_CLEAR_HOLD_MODE);
    step(RRE_OP_IRQ_TAKE);
    step(RRE_OP_PAIR_ROTATE_LEFT);
    load();
    step(RRE_OP_IRQ_RETURN_ENABLE);
    step(RRE_OP_IRQ_TAKE);
    step(RRE_OP_IRQ_TAKE);
    load();
    step(RRE_OP_IRQ_RETURN);
    step(RRE_OP_IRQ_RETURN);
    step(RRE_OP_PUSH_CALL);
    step(RRE_OP_COND_RETURN, 8'h05, 8'h04);
    step(RRE_OP_COND_RETURN, 8'h05, 8'h0f);
    step(RRE_OP_PUSH_CALL);
    step(RRE_OP_PUSH_CALL);
    step(RRE_OP_COND_RETURN_DELAYED, 8'h81, 8'h81);
    step(RRE_OP_ACC_ROTATE_LEFT);
    step(RRE_OP_COND_RETURN);
    step(RRE_OP_COND_RETURN);
    step(RRE_OP_NOP);
    @(posedge SYS_CLK);
    #5;
    give_verdict();
  end
  // Watchdog, far beyond the few dozen cycles the run needs
  initial
  begin
    #100us;
    $display("CHECK FAILED %0t: run did not finish", $time);
    err_total++;
    give_verdict();
  end
endmodule
